// [hdl/pssc_pkg.sv]
// Functional notes
// - Wake phases exit only after dwell elapsed and all enabled supplies good.
// - Dwell field 20:16 holds log2 cycle count, 2^n cycles, reset 16.
// - Bit 14 set gates the processor tile clock while in that state.
// - Bit 9 picks analogue converter modulation: 0 PWM 475 mA, 1 PFM 50 mA.
// - Bit 8 picks core converter modulation: 0 PWM 700 mA, 1 PFM 50 mA.
// - Bit 5 set enables the IO supply output in that state.
// - Bit 4 set enables the PLL linear regulator in that state.
// - Bit 1 analogue converter enable is read-only, fixed per state.
// - Bit 0 set enables the core converter in that state.
// - Awake register has no dwell; awake holds until a sleep request.
// - First sleep phase lasts exactly its dwell, ignoring supply status.
// - Wake phase one resets to IO supply only, dwell 16.
// - Wake phase two resets to IO, PLL and both converters, PWM, clock on.
// - State code: 0 reset,1 asleep,2 wake1,3 wake2,4 wait,5 awake,6 sleep1,7 sleep2.
// - Dwell counts cycles of the selected sequencer clock.
// - Sleep request bit is self-clearing and acts only while awake.
// - Self-clearing re-apply bit drives supplies from new awake contents.
package pssc_pkg;
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_WAKE1  = 8'h10;
   localparam logic [7:0]  OFF_WAKE2  = 8'h14;
   localparam logic [7:0]  OFF_AWAKE  = 8'h18;
   localparam logic [7:0]  OFF_SLEEP1 = 8'h1c;
   localparam logic [7:0]  OFF_STATUS = 8'h24;

   localparam int          BIT_CLK_SEL   = 0;
   localparam int          BIT_SLEEP_REQ = 1;
   localparam int          BIT_REAPPLY   = 6;

   localparam int          BIT_CORE_EN   = 0;
   localparam int          BIT_ANA_EN    = 1;
   localparam int          BIT_PLL_EN    = 4;
   localparam int          BIT_IO_EN     = 5;
   localparam int          BIT_CORE_PFM  = 8;
   localparam int          BIT_ANA_PFM   = 9;
   localparam int          BIT_TILE_GATE = 14;
   localparam int          DWELL_LSB     = 16;
   localparam int          DWELL_MSB     = 20;
   localparam int          STATE_LSB     = 16;
   localparam int          STATE_MSB     = 18;

   localparam logic [31:0] MASK_TIMED = 32'h001f_4331;
   localparam logic [31:0] MASK_AWAKE = 32'h0000_4331;
   localparam logic [31:0] RST_WAKE1  = 32'h0010_0020;
   localparam logic [31:0] RST_WAKE2  = 32'h0010_0031;
   localparam logic [31:0] RST_AWAKE  = 32'h0000_0031;
   localparam logic [31:0] RST_SLEEP1 = 32'h0010_0020;
   localparam logic        ANA_WAKE1  = 1'b0;
   localparam logic        ANA_WAKE2  = 1'b1;
   localparam logic        ANA_AWAKE  = 1'b1;
   localparam logic        ANA_SLEEP1 = 1'b1;
   localparam logic        RST_CLK_SEL = 1'b0;

   typedef enum logic [7:0] {
      ST_RESET  = 8'h01,
      ST_ASLEEP = 8'h02,
      ST_WAKE1  = 8'h04,
      ST_WAKE2  = 8'h08,
      ST_AWAIT  = 8'h10,
      ST_AWAKE  = 8'h20,
      ST_SLEEP1 = 8'h40,
      ST_SLEEP2 = 8'h80
   } pssc_state_e;

   function automatic logic [2:0] pssc_code(input pssc_state_e s);
      case (s)
         ST_RESET:  pssc_code = 3'h0;
         ST_ASLEEP: pssc_code = 3'h1;
         ST_WAKE1:  pssc_code = 3'h2;
         ST_WAKE2:  pssc_code = 3'h3;
         ST_AWAIT:  pssc_code = 3'h4;
         ST_AWAKE:  pssc_code = 3'h5;
         ST_SLEEP1: pssc_code = 3'h6;
         ST_SLEEP2: pssc_code = 3'h7;
         default:   pssc_code = 3'h0;
      endcase
   endfunction
endpackage

// [hdl/pssc_dwell_if.sv]
`timescale 1ns/1ns
interface pssc_dwell_if;
   logic       restart;
   logic       tick;
   logic [4:0] log2;
   logic       expired;
   modport seq   (output restart, output tick, output log2, input expired);
   modport timer (input restart, input tick, input log2, output expired);
endinterface

// [hdl/pssc_sync.sv]
`timescale 1ns/1ns
module pssc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // pssc_sync

// [hdl/pssc_dwell.sv]
`timescale 1ns/1ns
module pssc_dwell #(
   parameter int CNT_W = 32
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   pssc_dwell_if.timer dw
);
   if (CNT_W < 32) begin : g_bad_width
      $error("Dwell counter must hold 2^31");
   end

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] limit;

   assign limit = {{(CNT_W-1){1'b0}}, 1'b1} << dw.log2;

   // Saturates at the limit so a long wait on power good never wraps
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (dw.restart) begin
         cnt <= '0;
      end else if (dw.tick && cnt < limit) begin
         cnt <= cnt + 1'b1;
      end
   end

   assign dw.expired = (cnt >= limit) || (dw.tick && cnt == limit - 1'b1);
endmodule // pssc_dwell

// [hdl/pssc_top.sv]
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module pssc_top (
   input  wire logic        MCLK,
   input  wire logic        NRST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        PGOOD_CORE,
   input  wire logic        PGOOD_ANA,
   input  wire logic        PGOOD_IO,
   input  wire logic        PGOOD_PLL,
   input  wire logic        WAKE_REQ,
   input  wire logic        SLOW_CLK_IN,
   output logic             CORE_CONV_EN,
   output logic             ANA_CONV_EN,
   output logic             CORE_CONV_PFM,
   output logic             ANA_CONV_PFM,
   output logic             IO_SUPPLY_EN,
   output logic             PLL_REG_EN,
   output logic             TILE_CLK_GATE
);
   ////////////////////////////////////////////////////////////////////////
   pssc_pkg::pssc_state_e st;
   pssc_pkg::pssc_state_e next_st;
   logic [31:0]           cfg_w1;
   logic [31:0]           cfg_w2;
   logic [31:0]           cfg_aw;
   logic [31:0]           cfg_s1;
   logic [31:0]           applied;
   logic [31:0]           next_cfg;
   logic [31:0]           rd_val;
   logic                  clk_sel;
   logic [3:0]            good;
   logic                  wake_s;
   logic                  slow_s;
   logic                  slow_d;
   logic                  slow_edge;
   logic                  all_good;
   logic                  apb_setup;
   logic                  apb_write;
   logic                  ctrl_wr;
   logic                  sleep_req;
   logic                  reapply;
   logic                  rd_ok;

   pssc_dwell_if dw ();

   ////////////////////////////////////////////////////////////////////////
   // Pins from the regulators and the slow oscillator are asynchronous
   pssc_sync #(.W(6)) u_sync (
      .clk   (MCLK),
      .rst_n (NRST),
      .d     ({SLOW_CLK_IN, WAKE_REQ, PGOOD_PLL, PGOOD_IO, PGOOD_ANA, PGOOD_CORE}),
      .q     ({slow_s, wake_s, good})
   );

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         slow_d <= 1'b0;
      end else begin
         slow_d <= slow_s;
      end
   end

   assign slow_edge = slow_s && !slow_d;

   ////////////////////////////////////////////////////////////////////////
   // Read value of a supply register with its fixed analogue enable bit
   function automatic logic [31:0] with_ana(input logic [31:0] v, input logic a);
      with_ana = v | ({31'h0, a} << pssc_pkg::BIT_ANA_EN);
   endfunction

   function automatic logic [31:0] masked(input logic [31:0] v, input logic timed);
      masked = v & (timed ? pssc_pkg::MASK_TIMED : pssc_pkg::MASK_AWAKE);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data captured in the setup cycle
   assign apb_setup = PSEL && !PENABLE;
   assign apb_write = PSEL && PENABLE && PWRITE;
   assign PREADY    = 1'b1;
   assign ctrl_wr   = apb_write && PADDR == pssc_pkg::OFF_CTRL;
   assign sleep_req = ctrl_wr && PWDATA[pssc_pkg::BIT_SLEEP_REQ] && st == pssc_pkg::ST_AWAKE;
   assign reapply   = ctrl_wr && PWDATA[pssc_pkg::BIT_REAPPLY] && st == pssc_pkg::ST_AWAKE;

   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 32'h0;
      case (PADDR)
         pssc_pkg::OFF_CTRL:   rd_val = {31'h0, clk_sel};
         pssc_pkg::OFF_WAKE1:  rd_val = with_ana(cfg_w1, pssc_pkg::ANA_WAKE1);
         pssc_pkg::OFF_WAKE2:  rd_val = with_ana(cfg_w2, pssc_pkg::ANA_WAKE2);
         pssc_pkg::OFF_AWAKE:  rd_val = with_ana(cfg_aw, pssc_pkg::ANA_AWAKE);
         pssc_pkg::OFF_SLEEP1: rd_val = with_ana(cfg_s1, pssc_pkg::ANA_SLEEP1);
         pssc_pkg::OFF_STATUS: begin
            rd_val = applied;
            rd_val[pssc_pkg::STATE_MSB:pssc_pkg::STATE_LSB] = pssc_pkg::pssc_code(st);
         end
         default:              rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end else if (apb_setup) begin
         PRDATA  <= PWRITE ? 32'h0 : rd_val;
         PSLVERR <= !rd_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Supply registers; the analogue enable bit is never stored
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         cfg_w1 <= pssc_pkg::RST_WAKE1;
         cfg_w2 <= pssc_pkg::RST_WAKE2;
         cfg_aw <= pssc_pkg::RST_AWAKE;
         cfg_s1 <= pssc_pkg::RST_SLEEP1;
      end else if (apb_write) begin
         case (PADDR)
            pssc_pkg::OFF_WAKE1:  cfg_w1 <= masked(PWDATA, 1'b1);
            pssc_pkg::OFF_WAKE2:  cfg_w2 <= masked(PWDATA, 1'b1);
            pssc_pkg::OFF_AWAKE:  cfg_aw <= masked(PWDATA, 1'b0);
            pssc_pkg::OFF_SLEEP1: cfg_s1 <= masked(PWDATA, 1'b1);
            default:              ;
         endcase
      end
   end

   // Sleep request and re-apply are pulses, so only the clock select is held
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         clk_sel <= pssc_pkg::RST_CLK_SEL;
      end else if (ctrl_wr) begin
         clk_sel <= PWDATA[pssc_pkg::BIT_CLK_SEL];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   assign all_good = &(~{applied[pssc_pkg::BIT_PLL_EN], applied[pssc_pkg::BIT_IO_EN],
                         applied[pssc_pkg::BIT_ANA_EN], applied[pssc_pkg::BIT_CORE_EN]} | good);

   always_comb begin
      next_st = st;
      case (st)
         pssc_pkg::ST_RESET:  next_st = pssc_pkg::ST_WAKE1;
         pssc_pkg::ST_ASLEEP: begin
            if (wake_s) begin
               next_st = pssc_pkg::ST_WAKE1;
            end
         end
         pssc_pkg::ST_WAKE1: begin
            if (dw.expired && all_good) begin
               next_st = pssc_pkg::ST_WAKE2;
            end
         end
         pssc_pkg::ST_WAKE2: begin
            if (dw.expired && all_good) begin
               next_st = pssc_pkg::ST_AWAIT;
            end
         end
         pssc_pkg::ST_AWAIT:  next_st = pssc_pkg::ST_AWAKE;
         pssc_pkg::ST_AWAKE: begin
            if (sleep_req) begin
               next_st = pssc_pkg::ST_SLEEP1;
            end
         end
         pssc_pkg::ST_SLEEP1: begin
            if (dw.expired) begin
               next_st = pssc_pkg::ST_SLEEP2;
            end
         end
         pssc_pkg::ST_SLEEP2: next_st = pssc_pkg::ST_ASLEEP;
         default:             next_st = pssc_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         st <= pssc_pkg::ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Supply word for the state being entered; unconfigured states drive all off
   always_comb begin
      case (next_st)
         pssc_pkg::ST_WAKE1:  next_cfg = with_ana(cfg_w1, pssc_pkg::ANA_WAKE1);
         pssc_pkg::ST_WAKE2:  next_cfg = with_ana(cfg_w2, pssc_pkg::ANA_WAKE2);
         pssc_pkg::ST_AWAIT:  next_cfg = with_ana(cfg_aw, pssc_pkg::ANA_AWAKE);
         pssc_pkg::ST_AWAKE:  next_cfg = with_ana(cfg_aw, pssc_pkg::ANA_AWAKE);
         pssc_pkg::ST_SLEEP1: next_cfg = with_ana(cfg_s1, pssc_pkg::ANA_SLEEP1);
         default:             next_cfg = 32'h0;
      endcase
   end

   // Latched on entry so software edits mid-state do not glitch the supplies
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         applied <= 32'h0;
      end else if (next_st != st) begin
         applied <= next_cfg & ~pssc_pkg::MASK_TIMED | next_cfg & pssc_pkg::MASK_AWAKE;
      end else if (reapply) begin
         applied <= with_ana(cfg_aw, pssc_pkg::ANA_AWAKE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Dwell timer on the current state's field
   assign dw.restart = next_st != st;
   assign dw.tick    = clk_sel ? 1'b1 : slow_edge;

   always_comb begin
      case (st)
         pssc_pkg::ST_WAKE1:  dw.log2 = cfg_w1[pssc_pkg::DWELL_MSB:pssc_pkg::DWELL_LSB];
         pssc_pkg::ST_WAKE2:  dw.log2 = cfg_w2[pssc_pkg::DWELL_MSB:pssc_pkg::DWELL_LSB];
         pssc_pkg::ST_SLEEP1: dw.log2 = cfg_s1[pssc_pkg::DWELL_MSB:pssc_pkg::DWELL_LSB];
         default:             dw.log2 = 5'h0;
      endcase
   end

   pssc_dwell #(.CNT_W(32)) u_dwell (
      .clk   (MCLK),
      .rst_n (NRST),
      .dw    (dw)
   );

   ////////////////////////////////////////////////////////////////////////
   assign CORE_CONV_EN  = applied[pssc_pkg::BIT_CORE_EN];
   assign ANA_CONV_EN   = applied[pssc_pkg::BIT_ANA_EN];
   assign CORE_CONV_PFM = applied[pssc_pkg::BIT_CORE_PFM];
   assign ANA_CONV_PFM  = applied[pssc_pkg::BIT_ANA_PFM];
   assign IO_SUPPLY_EN  = applied[pssc_pkg::BIT_IO_EN];
   assign PLL_REG_EN    = applied[pssc_pkg::BIT_PLL_EN];
   assign TILE_CLK_GATE = applied[pssc_pkg::BIT_TILE_GATE];

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);

   logic in_w1;
   logic in_w2;
   logic in_aw;
   logic in_s1;
   logic entered;
   assign in_w1   = st == pssc_pkg::ST_WAKE1;
   assign in_w2   = st == pssc_pkg::ST_WAKE2;
   assign in_aw   = st == pssc_pkg::ST_AWAKE;
   assign in_s1   = st == pssc_pkg::ST_SLEEP1;

   // Registered copy of the state marks the first cycle of each state
   pssc_pkg::pssc_state_e prev_st;

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         prev_st <= pssc_pkg::ST_RESET;
      end else begin
         prev_st <= st;
      end
   end

   assign entered = st != prev_st;

   AST_WAKE_HOLD: assert property ((in_w1 || in_w2) && !all_good |=> st == $past(st))
      else $error("Wake phase left with a supply not good");
   AST_DWELL_ZERO: assert property (in_w1 && dw.tick && all_good
                                    && cfg_w1[pssc_pkg::DWELL_MSB:pssc_pkg::DWELL_LSB] == 5'h0
                                    |=> st == pssc_pkg::ST_WAKE2)
      else $error("Dwell of one cycle not honoured");
   AST_DWELL_ONE: assert property ($rose(in_w2) && clk_sel && all_good
                                   && cfg_w2[pssc_pkg::DWELL_MSB:pssc_pkg::DWELL_LSB] == 5'h1
                                   |=> in_w2 ##1 !in_w2)
      else $error("Dwell of two cycles not honoured");
   AST_TILE_ENTRY: assert property ($rose(in_s1) |-> TILE_CLK_GATE == $past(cfg_s1[pssc_pkg::BIT_TILE_GATE]))
      else $error("Tile clock gate not taken from entered state");
   AST_MOD_ENTRY: assert property ($rose(in_w2) |-> {ANA_CONV_PFM, CORE_CONV_PFM}
                                   == $past(cfg_w2[pssc_pkg::BIT_ANA_PFM:pssc_pkg::BIT_CORE_PFM]))
      else $error("Converter modulation not taken from entered state");
   AST_SUPPLY_ENTRY: assert property ($rose(in_w1) |-> {IO_SUPPLY_EN, PLL_REG_EN, CORE_CONV_EN}
                                      == {$past(cfg_w1[pssc_pkg::BIT_IO_EN]), $past(cfg_w1[pssc_pkg::BIT_PLL_EN]),
                                          $past(cfg_w1[pssc_pkg::BIT_CORE_EN])})
      else $error("Supply enables not taken from entered state");
   AST_ANA_FIXED: assert property (in_w1 |-> !ANA_CONV_EN)
      else $error("Analogue converter on in wake phase one");
   AST_AWAKE_STAY: assert property (in_aw && !sleep_req |=> in_aw)
      else $error("Awake left without a sleep request");
   AST_SLEEP_FIXED: assert property (in_s1 && dw.expired |=> st == pssc_pkg::ST_SLEEP2)
      else $error("Sleep phase one did not end on dwell");
   AST_SLEEP_REQ: assert property (sleep_req |=> in_s1 && entered)
      else $error("Sleep request did not start sleep phase one");
   AST_REAPPLY: assert property (reapply && !sleep_req |=> IO_SUPPLY_EN == $past(cfg_aw[pssc_pkg::BIT_IO_EN])
                                 && TILE_CLK_GATE == $past(cfg_aw[pssc_pkg::BIT_TILE_GATE]))
      else $error("Re-apply did not refresh awake supplies");
   AST_ORDER: assert property (st == pssc_pkg::ST_AWAIT |=> in_aw)
      else $error("Awake-wait not followed by awake");
   AST_RESERVED: assert property (apb_setup && !PWRITE && PADDR == pssc_pkg::OFF_AWAKE
                                  |=> PRDATA[31:15] == 17'h0 && PRDATA[13:10] == 4'h0)
      else $error("Reserved bits read nonzero");
   AST_STATE_CODE: assert property (apb_setup && !PWRITE && PADDR == pssc_pkg::OFF_STATUS && in_aw
                                    |=> PRDATA[pssc_pkg::STATE_MSB:pssc_pkg::STATE_LSB] == 3'h5)
      else $error("Status state code wrong");
   AST_CODE_WAKE1: assert property (apb_setup && !PWRITE && PADDR == pssc_pkg::OFF_STATUS && in_w1
                                    |=> PRDATA[pssc_pkg::STATE_MSB:pssc_pkg::STATE_LSB] == 3'h2)
      else $error("Status state code wrong in wake phase one");

   // Single supplies taken from the register of the state just entered
   AST_ANA_ON: assert property ($rose(in_w2) || $rose(in_s1) |-> ANA_CONV_EN)
      else $error("Analogue converter off in a state that fixes it on");
   AST_PLL_ENTRY: assert property ($rose(in_w2)
                                   |-> PLL_REG_EN == $past(cfg_w2[pssc_pkg::BIT_PLL_EN]))
      else $error("PLL regulator enable not taken from entered state");
   AST_CORE_ENTRY: assert property ($rose(in_w2)
                                    |-> CORE_CONV_EN == $past(cfg_w2[pssc_pkg::BIT_CORE_EN]))
      else $error("Core converter enable not taken from entered state");
   AST_IO_ENTRY: assert property ($rose(in_s1)
                                  |-> IO_SUPPLY_EN == $past(cfg_s1[pssc_pkg::BIT_IO_EN]))
      else $error("IO supply enable not taken from entered state");
   AST_TILE_AWAKE: assert property (st == pssc_pkg::ST_AWAIT
                                    |-> TILE_CLK_GATE == $past(cfg_aw[pssc_pkg::BIT_TILE_GATE]))
      else $error("Tile clock gate not taken from awake state");

   // Supplies move only on a state change or an explicit re-apply
   AST_OUTS_STABLE: assert property (!entered && !$past(reapply) |-> $stable(applied))
      else $error("Supply outputs changed inside a state");
   AST_SLEEP2_PASS: assert property (st == pssc_pkg::ST_SLEEP2 |=> st == pssc_pkg::ST_ASLEEP)
      else $error("Sleep phase two not followed by asleep");
   AST_ASLEEP_OFF: assert property (st == pssc_pkg::ST_ASLEEP |-> applied == 32'h0)
      else $error("Supplies on while asleep");
   AST_WAKE_ENTRY: assert property (st == pssc_pkg::ST_ASLEEP && wake_s |=> in_w1)
      else $error("Wake request did not start wake phase one");

   COV_AWAKE:   cover property (st == pssc_pkg::ST_AWAIT ##1 in_aw);
   COV_SLEEP:   cover property (sleep_req ##1 in_s1);
   COV_ASLEEP:  cover property (st == pssc_pkg::ST_ASLEEP);
   COV_REAPPLY: cover property (reapply);
   COV_ERR:     cover property (PSEL && PENABLE && PSLVERR);
endmodule // pssc_top

// [verification/pssc_supply_model.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module pssc_supply_model #(
   parameter int DLY = 3
) (
   input  wire logic       clk,
   input  wire logic [3:0] en,
   input  wire logic [3:0] hold,
   output logic      [3:0] pgood
);
   // A disabled output discharges at once, so good never lingers after disable
   logic [3:0] ramp [4];

   always_ff @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (!en[i])
            ramp[i] <= 4'h0;
         else if (ramp[i] < 4'(DLY))
            ramp[i] <= ramp[i] + 4'h1;
      end
   end

   // Hold models a slow regulator that the bench keeps from reaching regulation
   always_comb begin
      for (int i = 0; i < 4; i++)
         pgood[i] = en[i] & (ramp[i] >= 4'(DLY)) & ~hold[i];
   end
endmodule // pssc_supply_model

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench;
   typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp; logic err;} pssc_row_s;
   logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, wake_req;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata_q;
   logic [3:0]  hold, pgood;
   logic        err_q, core_en, ana_en, core_pfm, ana_pfm, io_en, pll_en, tile_gate;
   int          mismatches = 0;
   int          num_checks = 0;
   int          n;
   pssc_row_s   rows [9] = '{
      '{1'b0, 8'h10, 32'h0, 32'h0010_0020, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0010_0033, 1'b0},
      '{1'b0, 8'h18, 32'h0, 32'h0000_0033, 1'b0}, '{1'b0, 8'h1c, 32'h0, 32'h0010_0022, 1'b0},
      '{1'b1, 8'h30, 32'hffff_ffff, 32'h0, 1'b1}, '{1'b1, 8'h10, 32'hffff_ffff, 32'h001f_4331, 1'b0},
      '{1'b1, 8'h14, 32'h0, 32'h0000_0002, 1'b0}, '{1'b1, 8'h1c, 32'hffff_fffd, 32'h001f_4333, 1'b0},
      '{1'b1, 8'h18, 32'hffff_ffff, 32'h0000_4333, 1'b0}};

   pssc_top dut (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PGOOD_CORE(pgood[0]),
      .PGOOD_ANA(pgood[1]), .PGOOD_IO(pgood[2]), .PGOOD_PLL(pgood[3]), .WAKE_REQ(wake_req),
      .SLOW_CLK_IN(1'b0), .CORE_CONV_EN(core_en), .ANA_CONV_EN(ana_en), .CORE_CONV_PFM(core_pfm),
      .ANA_CONV_PFM(ana_pfm), .IO_SUPPLY_EN(io_en), .PLL_REG_EN(pll_en), .TILE_CLK_GATE(tile_gate));
   pssc_supply_model #(.DLY(3)) partner (.clk(mclk), .en({pll_en, io_en, ana_en, core_en}), .hold(hold),
      .pgood(pgood));

   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [6:0] outs();
      return {tile_gate, ana_pfm, core_pfm, io_en, pll_en, ana_en, core_en};
   endfunction

   task automatic chk_out(input string what, input logic [6:0] exp);
      num_checks++;
      if (outs() !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, outs());
      end
      $display("Test %s done", what);
   endtask

   // Bounded wait; a miss shows up in the check that follows
   task automatic wait_out(input logic [6:0] exp, input int limit);
      n = 0;
      while (outs() !== exp && n < limit) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Waits as long as the slave stretches the access; only the watchdog ends a hang
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rdata_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk32("pready", 1'b1, pready);
   endtask

   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #300000;
      mismatches++;
      $display("Error watchdog expected completion seen hang");
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0; nrst = 0; wake_req = 0; hold = 4'h0;
      repeat (2) @(posedge mclk);
      #1 chk_out("in reset", 7'h00);
      @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      #1 chk_out("wake one after reset", 7'h08);
      apb(1'b0, 8'h24, 32'h0);
      chk32("state code", 3'h2, rdata_q[18:16]);
      foreach (rows[i]) begin
         if (rows[i].wr)
            apb(1'b1, rows[i].addr, rows[i].wdata);
         apb(1'b0, rows[i].addr, 32'h0);
         chk32($sformatf("read %h", rows[i].addr), rows[i].exp, rdata_q);
         chk32($sformatf("error %h", rows[i].addr), rows[i].err, err_q);
      end
      apb(1'b1, 8'h10, 32'h0000_0021);
      apb(1'b1, 8'h14, 32'h0003_0131);
      apb(1'b1, 8'h18, 32'h0000_4231);
      apb(1'b1, 8'h1c, 32'h0002_0020);
      // Dwell ticks only start here, so every state already holds its new contents
      apb(1'b1, 8'h00, 32'h3);
      #1 chk_out("sleep refused in wake", 7'h08);
      wait_out(7'h1f, 40);
      chk_out("wake two", 7'h1f);
      wait_out(7'h6f, 200);
      chk_out("awake", 7'h6f);
      apb(1'b0, 8'h24, 32'h0);
      chk32("awake status", 32'h0005_4233, rdata_q);
      repeat (50) @(posedge mclk);
      #1 chk_out("awake holds", 7'h6f);
      apb(1'b1, 8'h18, 32'h0000_0031);
      #1 chk_out("awake edit pending", 7'h6f);
      apb(1'b1, 8'h00, 32'h41);
      #1 chk_out("awake reapplied", 7'h0f);
      hold <= 4'hf;
      apb(1'b1, 8'h00, 32'h3);
      #1 chk_out("sleep one", 7'h0a);
      wait_out(7'h00, 40);
      chk32("sleep one cycles", 32'd4, n);
      repeat (3) @(posedge mclk);
      apb(1'b0, 8'h24, 32'h0);
      chk32("asleep code", 3'h1, rdata_q[18:16]);
      hold <= 4'h1;
      wake_req <= 1'b1;
      wait_out(7'h09, 40);
      chk_out("wake one again", 7'h09);
      wake_req <= 1'b0;
      repeat (40) @(posedge mclk);
      #1 chk_out("wake held by supply", 7'h09);
      hold <= 4'h0;
      wait_out(7'h1f, 40);
      chk_out("wake released", 7'h1f);
      give_verdict();
   end
endmodule // testbench
